// File: rtl/cdtmr_top.sv
// Two sets of three 24-bit countdown timer channels behind a plain register port
//
// Function
// R01: Each channel holds a writable 24-bit reload value, reset to zero, in its first register.
// R02: Each channel shows its present 24-bit count read-only; writes leave it alone.
// R03: A channel counts only while control bit 0 is one; it resets to zero.
// R04: Control bit 1 picks free-running (0) or user-defined count (1) mode; resets to zero.
// R05: Control bit 2 masks the channel interrupt when one; resets to zero.
// R06: Reading the acknowledge register returns zero and clears the pending interrupt.
// R07: Status bit 0 shows whether the interrupt is pending, masked or not; other bits read zero.
// R08: The counters advance at a 4 MHz timer rate.
// R09: Two identical timer sets sit at two separate base addresses.
// R10: Unused upper bits of reload, count and control read as zero and ignore writes.
// R11: Channel two repeats the five-register layout starting at offset 0x14.
// R12: Channel three repeats the layout right after channel two.
// R13: Enabled, a channel loads its reload value, counts down, flags at zero and reloads.
// R14: A channel interrupt output is high only while pending and unmasked; irq_o is registered and follows them one cycle late.
//
// The plain strobed port is this design's own decision.
`include "cdtmr_defs.svh"

module cdtmr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Channel interrupts, set A channels 0..2 then set B
  output logic [`CDTMR_NUM_TMR-1:0] irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_s1_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer rate

  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic tick_reg;
  wire [16:0] acc_sum = {1'b0, acc_reg} + {1'b0, `CDTMR_TMR_CLK_KHZ};
  wire acc_wrap = (acc_sum >= {1'b0, `CDTMR_SYS_CLK_KHZ});

  // Fractional step gives 4 ticks per microsecond on average
  assign acc_next = acc_wrap ? 16'(acc_sum - {1'b0, `CDTMR_SYS_CLK_KHZ})  // see R08
                             : acc_sum[15:0];

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      acc_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= acc_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Offset within a channel's block to register kind
  function automatic cdtmr_pkg::cdtmr_reg_t reg_of(input logic [11:0] rel);
    cdtmr_pkg::cdtmr_reg_t r;
    r = cdtmr_pkg::CDTMR_R_NONE;
    if (rel == `CDTMR_RELOAD_OFS) begin
      r = cdtmr_pkg::CDTMR_R_RELOAD;
    end else if (rel == `CDTMR_COUNT_OFS) begin
      r = cdtmr_pkg::CDTMR_R_COUNT;
    end else if (rel == `CDTMR_CTRL_OFS) begin
      r = cdtmr_pkg::CDTMR_R_CTRL;
    end else if (rel == `CDTMR_ACK_OFS) begin
      r = cdtmr_pkg::CDTMR_R_ACK;
    end else if (rel == `CDTMR_FLAG_OFS) begin
      r = cdtmr_pkg::CDTMR_R_FLAG;
    end
    return r;
  endfunction

  // Channel number within a set from the offset
  function automatic logic [1:0] ch_of(input logic [11:0] off);
    logic [1:0] c;
    c = 2'd3;
    if (off < `CDTMR_CH_STRIDE) begin
      c = 2'd0;
    end else if (off < 12'(2 * `CDTMR_CH_STRIDE)) begin  // see R11
      c = 2'd1;
    end else if (off < 12'(3 * `CDTMR_CH_STRIDE)) begin  // see R12
      c = 2'd2;
    end
    return c;
  endfunction

  // Start offset of a channel's block
  function automatic logic [11:0] ch_base(input logic [1:0] c);
    return 12'(c * `CDTMR_CH_STRIDE);
  endfunction

  wire hit_a = ((addr_i & `CDTMR_BASE_MASK) == `CDTMR_BASE_A);  // see R09
  wire hit_b = ((addr_i & `CDTMR_BASE_MASK) == `CDTMR_BASE_B);  // see R09
  wire [11:0] off = addr_i[11:0];
  wire [1:0] ch_sel = ch_of(off);
  wire [11:0] rel_off = off - ch_base(ch_sel);
  cdtmr_pkg::cdtmr_reg_t reg_sel;
  assign reg_sel = (ch_sel == 2'd3) ? cdtmr_pkg::CDTMR_R_NONE : reg_of(rel_off);
  wire set_hit = hit_a | hit_b;
  wire acc_hit = set_hit & (reg_sel != cdtmr_pkg::CDTMR_R_NONE);
  cdtmr_pkg::cdtmr_idx_t idx;
  assign idx = hit_b ? 3'(ch_sel) + 3'(`CDTMR_NUM_CH) : 3'(ch_sel);  // see R09

  wire wr_reload = wr_i & acc_hit & (reg_sel == cdtmr_pkg::CDTMR_R_RELOAD);
  wire wr_ctrl = wr_i & acc_hit & (reg_sel == cdtmr_pkg::CDTMR_R_CTRL);
  wire rd_ack = rd_i & acc_hit & (reg_sel == cdtmr_pkg::CDTMR_R_ACK);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  cdtmr_pkg::cdtmr_cnt_t reload_reg [`CDTMR_NUM_TMR];
  logic [`CDTMR_CTRL_W-1:0] ctrl_reg [`CDTMR_NUM_TMR];

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int i = 0; i < `CDTMR_NUM_TMR; i++) begin
        reload_reg[i] <= `CDTMR_RELOAD_RST;  // see R01
        ctrl_reg[i] <= `CDTMR_CTRL_RST;  // see R03
      end
    end else begin
      if (wr_reload) begin
        reload_reg[idx] <= wdata_i[`CDTMR_CNT_W-1:0];  // see R01
      end
      if (wr_ctrl) begin
        ctrl_reg[idx] <= wdata_i[`CDTMR_CTRL_W-1:0];  // see R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channels

  cdtmr_ch_if ch_bus [`CDTMR_NUM_TMR] ();
  cdtmr_pkg::cdtmr_cnt_t count_w [`CDTMR_NUM_TMR];
  logic [`CDTMR_NUM_TMR-1:0] pending_w;

  for (genvar g = 0; g < `CDTMR_NUM_TMR; g++) begin : g_ch
    assign ch_bus[g].tick = tick_reg;  // see R08
    assign ch_bus[g].enable = ctrl_reg[g][`CDTMR_CTRL_EN_BIT];  // see R03
    assign ch_bus[g].mode = ctrl_reg[g][`CDTMR_CTRL_MODE_BIT];  // see R04
    assign ch_bus[g].reload = reload_reg[g];
    assign ch_bus[g].ack = rd_ack & (idx == 3'(g));  // see R06
    assign count_w[g] = ch_bus[g].count;
    assign pending_w[g] = ch_bus[g].pending;

    cdtmr_channel u_channel (
      .clk_i(clk_i),
      .rst_n_i(rst_n_reg),
      .ch(ch_bus[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs

  logic [`CDTMR_NUM_TMR-1:0] irq_reg;
  logic [`CDTMR_NUM_TMR-1:0] irq_next;

  for (genvar g = 0; g < `CDTMR_NUM_TMR; g++) begin : g_irq
    assign irq_next[g] = pending_w[g] & ~ctrl_reg[g][`CDTMR_CTRL_MASK_BIT];  // see R05 R14
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [31:0] rd_reload = {8'h00, reload_reg[idx]};  // see R10
  wire [31:0] rd_count = {8'h00, count_w[idx]};  // see R02
  wire [31:0] rd_ctrl = {29'h0, ctrl_reg[idx]};  // see R10
  wire [31:0] rd_flag = {31'h0, pending_w[idx]};  // see R07
  wire [31:0] rd_word = !acc_hit ? 32'h0000_0000 :
                        (reg_sel == cdtmr_pkg::CDTMR_R_RELOAD) ? rd_reload :
                        (reg_sel == cdtmr_pkg::CDTMR_R_COUNT) ? rd_count :
                        (reg_sel == cdtmr_pkg::CDTMR_R_CTRL) ? rd_ctrl :
                        (reg_sel == cdtmr_pkg::CDTMR_R_FLAG) ? rd_flag :
                        32'h0000_0000;  // see R06

  logic [31:0] rdata_reg;

  // Data stand only in the cycle after the read
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rd_i ? rd_word : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;

endmodule

// File: inc/cdtmr_defs.svh
// Offsets, field positions, reset values and timing figures of the timer set
`ifndef CDTMR_DEFS_SVH
`define CDTMR_DEFS_SVH

// Set bases
`define CDTMR_BASE_A 32'h4000_1000
`define CDTMR_BASE_B 32'h4002_1000
`define CDTMR_BASE_MASK 32'hffff_f000

// Channel layout
`define CDTMR_NUM_SET 2
`define CDTMR_NUM_CH 3
`define CDTMR_NUM_TMR 6
`define CDTMR_CH_STRIDE 12'h014
`define CDTMR_RELOAD_OFS 12'h000
`define CDTMR_COUNT_OFS 12'h004
`define CDTMR_CTRL_OFS 12'h008
`define CDTMR_ACK_OFS 12'h00c
`define CDTMR_FLAG_OFS 12'h010

// Fields
`define CDTMR_CNT_W 24
`define CDTMR_CTRL_W 3
`define CDTMR_CTRL_EN_BIT 0
`define CDTMR_CTRL_MODE_BIT 1
`define CDTMR_CTRL_MASK_BIT 2
`define CDTMR_FLAG_BIT 0

// Reset values and the free-running wrap value
`define CDTMR_RELOAD_RST 24'h00_0000
`define CDTMR_CTRL_RST 3'h0
`define CDTMR_COUNT_RST 24'h00_0000
`define CDTMR_FREE_RELOAD 24'hff_ffff

// Timing: system clock and timer clock in kHz, tick by fractional accumulation
`define CDTMR_SYS_CLK_KHZ 16'd50000
`define CDTMR_TMR_CLK_KHZ 16'd4000

`endif

// File: inc/cdtmr_pkg.sv
// Types shared by the timer set modules
package cdtmr_pkg;
  typedef logic [23:0] cdtmr_cnt_t;
  typedef logic [2:0] cdtmr_idx_t;
  typedef enum logic [2:0] {
    CDTMR_R_RELOAD,
    CDTMR_R_COUNT,
    CDTMR_R_CTRL,
    CDTMR_R_ACK,
    CDTMR_R_FLAG,
    CDTMR_R_NONE
  } cdtmr_reg_t;
endpackage

// File: inc/cdtmr_ch_if.sv
// Signals between the register file and one counting channel
interface cdtmr_ch_if;
  logic tick;
  logic enable;
  logic mode;
  logic ack;
  cdtmr_pkg::cdtmr_cnt_t reload;
  cdtmr_pkg::cdtmr_cnt_t count;
  logic pending;

  modport ctl (
    output tick, enable, mode, ack, reload,
    input count, pending
  );
  modport chan (
    input tick, enable, mode, ack, reload,
    output count, pending
  );
endinterface

// File: rtl/cdtmr_channel.sv
// One down-counting timer channel with its pending flag
`include "cdtmr_defs.svh"

module cdtmr_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register side
  cdtmr_ch_if.chan ch
);

  logic en_d_reg;
  cdtmr_pkg::cdtmr_cnt_t count_reg;
  cdtmr_pkg::cdtmr_cnt_t count_next;
  logic pending_reg;
  logic pending_next;
  wire start = ch.enable & ~en_d_reg;
  wire step = ch.enable & ch.tick & ~start;
  wire at_zero = (count_reg == `CDTMR_COUNT_RST);
  wire expire = step & at_zero;
  wire [`CDTMR_CNT_W-1:0] wrap_val = ch.mode ? ch.reload : `CDTMR_FREE_RELOAD;

  // Load on enable, count down on tick, reload at zero
  assign count_next = start ? ch.reload :  // see R13
                      expire ? wrap_val :  // see R04
                      step ? count_reg - 24'h00_0001 :  // see R03
                      count_reg;
  // Expiry wins over acknowledge
  assign pending_next = expire | (pending_reg & ~ch.ack);  // see R06

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_d_reg <= 1'b0;
      count_reg <= `CDTMR_COUNT_RST;
      pending_reg <= 1'b0;
    end else begin
      en_d_reg <= ch.enable;
      count_reg <= count_next;
      pending_reg <= pending_next;
    end
  end

  assign ch.count = count_reg;
  assign ch.pending = pending_reg;

endmodule

// File: testbench/cdtmr_sva.sv
// Port-level checks for the timer set
`include "cdtmr_defs.svh"

module cdtmr_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Interrupts
  input wire logic [`CDTMR_NUM_TMR-1:0] irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [11:0] low = addr_i[11:0];
  wire a0 = addr_i[31:12] == 20'h40001;
  wire mapped = (a0 || addr_i[31:12] == 20'h40021) && low < 12'h03c;
  wire [11:0] ofs = low % 12'h014;
  wire rd_ack = rd_i && mapped && ofs == 12'h00c;
  wire rd_flag = rd_i && mapped && ofs == 12'h010;
  wire rd_ctrl = rd_i && mapped && ofs == 12'h008;
  wire rd_wide = rd_i && mapped && ofs < 12'h008;
  wire ack0 = rd_i && a0 && low == 12'h00c;
  wire clr0 = ack0 || (wr_i && a0 && low == 12'h008);
  wire flag0 = rd_i && a0 && low == 12'h010;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////
  a_ack_zero:
    assert property (rd_ack |=> rdata_o == 32'h0) else $error("ack read not zero");
  a_flag_upper:
    assert property (rd_flag |=> rdata_o[31:1] == 31'h0) else $error("status upper bits");
  a_ctrl_upper:
    assert property (rd_ctrl |=> rdata_o[31:3] == 29'h0) else $error("control upper bits");
  a_value_upper:
    assert property (rd_wide |=> rdata_o[31:24] == 8'h0) else $error("value upper bits");
  a_unmapped_zero:
    assert property (rd_i && !mapped |=> rdata_o == 32'h0) else $error("unmapped read");
  a_rdata_idle:
    assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data not idle");
  a_irq_fall:
    assert property ($fell(irq_o[0]) |-> $past(clr0) || $past(clr0, 2))
      else $error("irq fell without cause");
  a_flag_irq:
    assert property (flag0 && irq_o[0] && !$past(ack0) |=> rdata_o[0])
      else $error("status misses irq");
endmodule

bind cdtmr_top cdtmr_sva chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// File: testbench/tb_top.sv
// Register-level tests of the timer set
`include "cdtmr_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [`CDTMR_NUM_TMR-1:0] irq_o;
  logic [31:0] v;
  logic [31:0] w;
  int n_errors = 0;
  int num_checks = 0;

  cdtmr_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ra(input int s, input int c, input logic [11:0] o);
    return (s != 0 ? `CDTMR_BASE_B : `CDTMR_BASE_A) + 32'(c * 20) + 32'(o);
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  task automatic poll(input logic [31:0] a);
    logic [31:0] d;
    int k;
    d = 32'h0;
    k = 0;
    while (d[0] !== 1'b1 && k < 100) begin
      rd(a, d);
      k++;
    end
    chk("status", 32'h1, d);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values, layout and reserved bits
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 3; c++) begin
        for (int o = 0; o < 20; o += 4) begin
          rdc(ra(s, c, 12'(o)), 32'h0);
        end
        wr(ra(s, c, 12'h000), 32'hffff_ffff);
        rdc(ra(s, c, 12'h000), 32'h00ff_ffff);
        wr(ra(s, c, 12'h008), 32'hffff_fff8);
        rdc(ra(s, c, 12'h008), 32'h0);
        wr(ra(s, c, 12'h004), 32'h0000_0123);
        rdc(ra(s, c, 12'h004), 32'h0);
      end
    end
    rdc(32'h4000_1040, 32'h0);
    rdc(32'h4000_3000, 32'h0);
    // Every channel of both sets keeps its own reload value
    for (int t = 0; t < 6; t++) begin
      wr(ra(t / 3, t % 3, 12'h000), 32'(t + 16));
    end
    for (int t = 0; t < 6; t++) begin
      rdc(ra(t / 3, t % 3, 12'h000), 32'(t + 16));
    end
    // User-defined mode, acknowledge and mask
    wr(ra(0, 0, 12'h000), 32'h2);
    wr(ra(0, 0, 12'h008), 32'h3);
    poll(ra(0, 0, 12'h010));
    @(posedge clk_i);
    #1;
    chk("irq", 32'h1, 32'(irq_o));
    rd(ra(0, 0, 12'h004), v);
    chk("user reload", 32'h1, 32'(v <= 32'h2));
    rdc(ra(0, 0, 12'h010), 32'h1);
    rdc(ra(0, 0, 12'h00c), 32'h0);
    rdc(ra(0, 0, 12'h010), 32'h0);
    chk("irq", 32'h0, 32'(irq_o));
    wr(ra(0, 0, 12'h008), 32'h7);
    poll(ra(0, 0, 12'h010));
    chk("irq", 32'h0, 32'(irq_o));
    wr(ra(0, 0, 12'h008), 32'h0);
    @(posedge clk_i);
    #1;
    chk("irq", 32'h1, 32'(irq_o));
    rdc(ra(0, 0, 12'h00c), 32'h0);
    // Free-running mode, rate and hold when disabled
    wr(ra(1, 2, 12'h000), 32'h3);
    wr(ra(1, 2, 12'h008), 32'h1);
    poll(ra(1, 2, 12'h010));
    rd(ra(1, 2, 12'h004), v);
    repeat (123) @(posedge clk_i);
    rd(ra(1, 2, 12'h004), w);
    chk("free reload", 32'h1, 32'(v > 32'h00ff_fff0));
    chk("rate", 32'd10, v - w);
    chk("irq", 32'h20, 32'(irq_o));
    wr(ra(1, 2, 12'h008), 32'h0);
    rd(ra(1, 2, 12'h004), v);
    repeat (40) @(posedge clk_i);
    rdc(ra(1, 2, 12'h004), v);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
endmodule
